// File: rtl/drc_pkg.sv
// package for the reference converter control block: map, fields, types
package drc_pkg;
  // register byte addresses on the AXI4-Lite bus
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] LEVEL_ADDR = 4'h4;
  // control field positions
  localparam int EN_BIT = 7;
  localparam int OE1_BIT = 5;
  localparam int OE2_BIT = 4;
  localparam int PSS_LSB = 2;
  localparam int NSS_BIT = 0;
  // writable masks, unimplemented positions stay zero
  localparam logic [7:0] CTRL_MASK = 8'hBD;
  localparam logic [7:0] LEVEL_MASK = 8'h1F;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] LEVEL_RESET = 5'h00;
  localparam int LEVEL_WIDTH = 5;
  localparam int TAP_COUNT = 32;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // positive source codes
  typedef enum logic [1:0] {
    PSRC_SUPPLY = 2'h0,
    PSRC_EXT_REF = 2'h1,
    PSRC_FIXED_BUF = 2'h2,
    PSRC_RESERVED = 2'h3
  } drc_psrc_type;

  // control register layout
  typedef struct packed {
    logic enable;
    logic unused6;
    logic pin_one_output_enable;
    logic pin_two_output_enable;
    drc_psrc_type positive_source_select;
    logic unused1;
    logic negative_source_select;
  } drc_ctrl_type;

  // per-pin override bundle toward the port logic
  typedef struct packed {
    logic analog_route;
    logic driver_off;
    logic pullup_off;
    logic input_off;
  } drc_pin_type;

  // write channel state
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } drc_wstate_type;

  // complete module state
  typedef struct packed {
    drc_ctrl_type ctrl;
    logic [4:0] level;
    logic have_aw;
    logic have_w;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    drc_wstate_type wstate;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } drc_state_type;
endpackage : drc_pkg

// File: rtl/drc_top.sv
// reference converter control block with AXI4-Lite register slave
`timescale 1ns/1ns
module drc_top #(
  parameter int LEVEL_WIDTH = 5
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // axi4-lite write address and data
  input wire logic [3:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // axi4-lite read
  input wire logic [3:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // digital pin levels from the port logic
  input wire logic PIN_ONE_IN_I,
  input wire logic PIN_TWO_IN_I,
  // ladder control toward the analog core
  output logic CONVERTER_ENABLE_O,
  output logic [31:0] LADDER_TAP_O,
  output logic [1:0] POSITIVE_SOURCE_O,
  output logic POS_SOURCE_VALID_O,
  output logic NEGATIVE_SOURCE_O,
  // output routing to the selectable consumers
  output logic FIRST_OUTPUT_PIN_ROUTE_O,
  output logic SECOND_OUTPUT_PIN_ROUTE_O,
  output logic COMPARATOR_SOURCE_OK_O,
  output logic ADC_SOURCE_OK_O,
  // pin overrides and filtered digital reads
  output logic [3:0] PIN_ONE_OVERRIDE_O,
  output logic [3:0] PIN_TWO_OVERRIDE_O,
  output logic PIN_ONE_READ_O,
  output logic PIN_TWO_READ_O
);

  drc_pkg::drc_state_type state_reg;
  drc_pkg::drc_state_type state_next;
  drc_pkg::drc_ctrl_type ctrl_w;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [7:0] rd_byte;
  logic rd_hit;

  // handshake readies are combinational; one write and one read at a time
  assign aw_take = S_AXI_AWVALID_I && !state_reg.have_aw &&
                   state_reg.wstate == drc_pkg::WR_IDLE;
  assign w_take = S_AXI_WVALID_I && !state_reg.have_w &&
                  state_reg.wstate == drc_pkg::WR_IDLE;
  assign ar_take = S_AXI_ARVALID_I && !state_reg.rvalid;
  assign S_AXI_AWREADY_O = !state_reg.have_aw &&
                           state_reg.wstate == drc_pkg::WR_IDLE;
  assign S_AXI_WREADY_O = !state_reg.have_w &&
                          state_reg.wstate == drc_pkg::WR_IDLE;
  assign S_AXI_ARREADY_O = !state_reg.rvalid;
  assign S_AXI_BVALID_O = state_reg.wstate == drc_pkg::WR_RESP;
  assign S_AXI_BRESP_O = state_reg.bresp;
  assign S_AXI_RVALID_O = state_reg.rvalid;
  assign S_AXI_RDATA_O = state_reg.rdata;
  assign S_AXI_RRESP_O = state_reg.rresp;

  // read decode; masks keep unimplemented bits at zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR_I[3:2] == drc_pkg::CTRL_ADDR[3:2]) begin
      rd_byte = state_reg.ctrl & drc_pkg::CTRL_MASK;
    end else if (S_AXI_ARADDR_I[3:2] == drc_pkg::LEVEL_ADDR[3:2]) begin
      rd_byte = {3'h0, state_reg.level};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // next state: bus slave plus the two registers
  always_comb begin
    state_next = state_reg;
    ctrl_w = state_reg.ctrl;
    if (aw_take) begin
      state_next.have_aw = 1'b1;
      state_next.awaddr = S_AXI_AWADDR_I;
    end
    if (w_take) begin
      state_next.have_w = 1'b1;
      state_next.wdata = S_AXI_WDATA_I;
      state_next.wstrb = S_AXI_WSTRB_I;
    end
    case (state_reg.wstate)
      drc_pkg::WR_IDLE: begin
        if (state_reg.have_aw && state_reg.have_w) begin
          state_next.have_aw = 1'b0;
          state_next.have_w = 1'b0;
          state_next.wstate = drc_pkg::WR_RESP;
          state_next.bresp = drc_pkg::RESP_OKAY;
          // only byte lane 0 carries register bits
          if (state_reg.awaddr[3:2] == drc_pkg::CTRL_ADDR[3:2]) begin
            if (state_reg.wstrb[0]) begin
              ctrl_w = state_reg.wdata[7:0] & drc_pkg::CTRL_MASK;
              state_next.ctrl = ctrl_w;
            end
          end else if (state_reg.awaddr[3:2] ==
                       drc_pkg::LEVEL_ADDR[3:2]) begin
            if (state_reg.wstrb[0]) begin
              state_next.level = state_reg.wdata[4:0];
            end
          end else begin
            state_next.bresp = drc_pkg::RESP_SLVERR;
          end
        end
      end
      drc_pkg::WR_RESP: begin
        if (S_AXI_BREADY_I) begin
          state_next.wstate = drc_pkg::WR_IDLE;
        end
      end
      default: begin
        state_next.wstate = drc_pkg::WR_IDLE;
      end
    endcase
    // read answers one cycle after the address is taken
    if (ar_take) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = {24'h000000, rd_byte};
      state_next.rresp = rd_hit ? drc_pkg::RESP_OKAY : drc_pkg::RESP_SLVERR;
    end else if (state_reg.rvalid && S_AXI_RREADY_I) begin
      state_next.rvalid = 1'b0;
    end
  end

  // only device reset clears the state; sleep has no path in here
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg <= '0;
      state_reg.ctrl <= drc_pkg::CTRL_RESET;
      state_reg.level <= drc_pkg::LEVEL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ladder enable and source selection
  assign CONVERTER_ENABLE_O = state_reg.ctrl.enable;
  assign POSITIVE_SOURCE_O = state_reg.ctrl.positive_source_select;
  // reserved code leaves the top of the ladder unconnected
  assign POS_SOURCE_VALID_O = state_reg.ctrl.positive_source_select !=
                              drc_pkg::PSRC_RESERVED;
  assign NEGATIVE_SOURCE_O = state_reg.ctrl.negative_source_select;

  // one-hot tap: vout = vneg + span * code / 2^5, none while disabled
  genvar t;
  generate
    for (t = 0; t < drc_pkg::TAP_COUNT; t++) begin : g_tap
      assign LADDER_TAP_O[t] = state_reg.ctrl.enable &&
        (state_reg.level == LEVEL_WIDTH'(t));
    end
  endgenerate

  // pin routing follows its own enable even with the converter off
  assign FIRST_OUTPUT_PIN_ROUTE_O =
    state_reg.ctrl.pin_one_output_enable;
  assign SECOND_OUTPUT_PIN_ROUTE_O =
    state_reg.ctrl.pin_two_output_enable;
  assign COMPARATOR_SOURCE_OK_O = state_reg.ctrl.enable;
  assign ADC_SOURCE_OK_O = state_reg.ctrl.enable;

  // a routed pin loses driver, pull-up and input detector
  assign PIN_ONE_OVERRIDE_O = {4{state_reg.ctrl.pin_one_output_enable}};
  assign PIN_TWO_OVERRIDE_O = {4{state_reg.ctrl.pin_two_output_enable}};
  assign PIN_ONE_READ_O = PIN_ONE_IN_I &&
                          !state_reg.ctrl.pin_one_output_enable;
  assign PIN_TWO_READ_O = PIN_TWO_IN_I &&
                          !state_reg.ctrl.pin_two_output_enable;

endmodule : drc_top

// File: testbench/drc_properties.sv
// assertion checker for the converter control outputs
`timescale 1ns/1ns
module drc_properties (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // pin inputs and observed outputs
  input wire logic PIN_ONE_IN_I,
  input wire logic PIN_TWO_IN_I,
  input wire logic CONVERTER_ENABLE_O,
  input wire logic [31:0] LADDER_TAP_O,
  input wire logic [1:0] POSITIVE_SOURCE_O,
  input wire logic POS_SOURCE_VALID_O,
  input wire logic FIRST_OUTPUT_PIN_ROUTE_O,
  input wire logic SECOND_OUTPUT_PIN_ROUTE_O,
  input wire logic [3:0] PIN_ONE_OVERRIDE_O,
  input wire logic [3:0] PIN_TWO_OVERRIDE_O,
  input wire logic PIN_ONE_READ_O,
  input wire logic PIN_TWO_READ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // ladder quiet while off, exactly one tap while on
  property p_tap_off; !CONVERTER_ENABLE_O |-> LADDER_TAP_O == 32'h0; endproperty
  a_tap_off: assert property (p_tap_off) else $error("tap while off");
  property p_tap_hot; CONVERTER_ENABLE_O |-> $onehot(LADDER_TAP_O); endproperty
  a_tap_hot: assert property (p_tap_hot) else $error("tap not one-hot");
  // pin overrides follow routing
  property p_ovr1; PIN_ONE_OVERRIDE_O == {4{FIRST_OUTPUT_PIN_ROUTE_O}}; endproperty
  a_ovr1: assert property (p_ovr1) else $error("pin one override");
  property p_ovr2; PIN_TWO_OVERRIDE_O == {4{SECOND_OUTPUT_PIN_ROUTE_O}}; endproperty
  a_ovr2: assert property (p_ovr2) else $error("pin two override");
  // routed pins read zero, others pass through
  property p_rd1; PIN_ONE_READ_O == (PIN_ONE_IN_I && !FIRST_OUTPUT_PIN_ROUTE_O); endproperty
  a_rd1: assert property (p_rd1) else $error("pin one read");
  property p_rd2; PIN_TWO_READ_O == (PIN_TWO_IN_I && !SECOND_OUTPUT_PIN_ROUTE_O); endproperty
  a_rd2: assert property (p_rd2) else $error("pin two read");
  property p_psrc; POS_SOURCE_VALID_O == (POSITIVE_SOURCE_O != 2'h3); endproperty
  a_psrc: assert property (p_psrc) else $error("reserved source flag");
  // first edge out of reset: converter off, pins released
  property p_rst; $rose(RST_B_I) |-> !CONVERTER_ENABLE_O && !FIRST_OUTPUT_PIN_ROUTE_O && !SECOND_OUTPUT_PIN_ROUTE_O; endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
endmodule : drc_properties
bind drc_top drc_properties drc_properties_inst (.*);

// File: testbench/drc_top_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module drc_top_bench;
  logic CLK_I = 1'h0, RST_B_I = 1'h0, PIN_ONE_IN_I = 1'h0, PIN_TWO_IN_I = 1'h0;
  logic S_AXI_AWVALID_I = 1'h0, S_AXI_WVALID_I = 1'h0, S_AXI_BREADY_I = 1'h0;
  logic S_AXI_ARVALID_I = 1'h0, S_AXI_RREADY_I = 1'h0;
  logic [3:0] S_AXI_AWADDR_I = 4'h0, S_AXI_ARADDR_I = 4'h0, S_AXI_WSTRB_I = 4'hF;
  logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O, LADDER_TAP_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, POSITIVE_SOURCE_O;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  logic S_AXI_RVALID_O, CONVERTER_ENABLE_O, POS_SOURCE_VALID_O, NEGATIVE_SOURCE_O;
  logic FIRST_OUTPUT_PIN_ROUTE_O, SECOND_OUTPUT_PIN_ROUTE_O, PIN_ONE_READ_O;
  logic COMPARATOR_SOURCE_OK_O, ADC_SOURCE_OK_O, PIN_TWO_READ_O;
  logic [3:0] PIN_ONE_OVERRIDE_O, PIN_TWO_OVERRIDE_O;
  int error_cnt = 0, n_checks = 0;
  // rows: address, written byte, byte read back
  logic [19:0] rows [9] = '{20'h0FFBD, 20'h0A8A8, 20'h4FF1F, 20'h40000,
    20'h09494, 20'h40A0A, 20'h04200, 20'h03131, 20'h41515};
  drc_top drc_top_inst (.*);
  always #5 CLK_I = ~CLK_I;
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer; each channel released at its own handshake
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic [1:0] r);
    logic av, wv, done, aok, wok;
    int i;
    av = 1'h1;
    wv = we;
    done = 1'h0;
    @(posedge CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_ARADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= we;
    S_AXI_WVALID_I <= we;
    S_AXI_BREADY_I <= we;
    S_AXI_ARVALID_I <= !we;
    S_AXI_RREADY_I <= !we;
    for (i = 0; i < 50 && !done; i++) begin
      // look at settled outputs mid-cycle, act on them at the next edge
      @(negedge CLK_I);
      aok = av && (we ? S_AXI_AWREADY_O : S_AXI_ARREADY_O);
      wok = wv && S_AXI_WREADY_O;
      if (!av && !wv && (we ? S_AXI_BVALID_O : S_AXI_RVALID_O)) begin
        done = 1'h1;
        q = S_AXI_RDATA_O;
        r = we ? S_AXI_BRESP_O : S_AXI_RRESP_O;
      end
      @(posedge CLK_I);
      if (aok) begin
        av = 1'h0;
        S_AXI_AWVALID_I <= 1'h0;
        S_AXI_ARVALID_I <= 1'h0;
      end
      if (wok) begin
        wv = 1'h0;
        S_AXI_WVALID_I <= 1'h0;
      end
      if (done) begin
        S_AXI_BREADY_I <= 1'h0;
        S_AXI_RREADY_I <= 1'h0;
      end
    end
    if (!done) begin
      error_cnt++;
      test_done();
    end
  endtask : xfer
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    logic [3:0] a;
    logic [7:0] w, e, ctl;
    logic [4:0] lvl;
    ctl = 8'h00;
    lvl = 5'h00;
    repeat (12) @(posedge CLK_I);
    RST_B_I <= 1'h1;
    // table of register writes and resulting outputs
    foreach (rows[k]) begin
      {a, w, e} = rows[k];
      xfer(1'h1, a, {24'h0, w}, q, r);
      chk(r, 2'h0);
      xfer(1'h0, a, 32'h0, q, r);
      chk(q, {24'h0, e});
      if (a == drc_pkg::CTRL_ADDR) ctl = e;
      else lvl = e[4:0];
      chk({CONVERTER_ENABLE_O, FIRST_OUTPUT_PIN_ROUTE_O, SECOND_OUTPUT_PIN_ROUTE_O,
        POSITIVE_SOURCE_O, NEGATIVE_SOURCE_O}, {ctl[7], ctl[5:2], ctl[0]});
      chk(LADDER_TAP_O, ctl[7] ? 32'h1 << lvl : 32'h0);
      chk({COMPARATOR_SOURCE_OK_O, ADC_SOURCE_OK_O}, {2{ctl[7]}});
    end
    // routed pins read zero although the pins are high
    @(posedge CLK_I);
    PIN_ONE_IN_I <= 1'h1;
    PIN_TWO_IN_I <= 1'h1;
    @(negedge CLK_I);
    chk({PIN_ONE_READ_O, PIN_TWO_READ_O, PIN_ONE_OVERRIDE_O}, 32'h0F);
    // unmapped address refused
    xfer(1'h1, 4'h8, 32'hFF, q, r);
    chk(r, 2'h2);
    xfer(1'h0, 4'h8, 32'h0, q, r);
    chk({q[29:0], r}, 32'h2);
    // reset in mid-run clears everything
    xfer(1'h1, drc_pkg::CTRL_ADDR, 32'hB0, q, r);
    @(posedge CLK_I);
    RST_B_I <= 1'h0;
    @(negedge CLK_I);
    chk({CONVERTER_ENABLE_O, FIRST_OUTPUT_PIN_ROUTE_O,
      SECOND_OUTPUT_PIN_ROUTE_O}, 32'h0);
    chk(LADDER_TAP_O, 32'h0);
    @(posedge CLK_I);
    RST_B_I <= 1'h1;
    xfer(1'h0, drc_pkg::LEVEL_ADDR, 32'h0, q, r);
    chk(q, 32'h0);
    test_done();
  end
endmodule : drc_top_bench
